// ==== rtl/power_up_report_pkg.sv ====
/*
  Shared constants for the power-up serial report: timing, characters,
  report step sequence and checksum arithmetic.
  Assumes a single 125 MHz clock on both ends of the link.
*/
package power_up_report_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ         = 125000000;
  localparam int BAUD_BPS       = 1200;
  localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_BPS;
  localparam int POWERUP_MS     = 100;
  localparam int POWERUP_CYCLES_DEF = POWERUP_MS * (CLK_HZ / 1000);
  localparam int FRAME_BITS     = 10;
  localparam int CHAR_W         = 8;
  localparam int FIFO_DEPTH     = 16;
  localparam int COND_DIGITS    = 6;
  // ------------------------------------------------------------------
  // Characters
  // ------------------------------------------------------------------
  localparam logic [7:0] CHAR_TAB   = 8'h09;
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_LF    = 8'h0a;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_MINUS = 8'h2d;
  localparam logic [7:0] CHAR_POINT = 8'h2e;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] ADDR_ZERO  = 8'h30;
  localparam logic [7:0] CSUM_OFFSET = 8'h20;
  // ------------------------------------------------------------------
  // Report steps, in send order
  // ------------------------------------------------------------------
  localparam logic [4:0] STEP_TAB    = 5'h00;
  localparam logic [4:0] STEP_COND   = 5'h01;
  localparam logic [4:0] STEP_SPACE  = 5'h07;
  localparam logic [4:0] STEP_SIGN   = 5'h08;
  localparam logic [4:0] STEP_TENS   = 5'h09;
  localparam logic [4:0] STEP_UNITS  = 5'h0a;
  localparam logic [4:0] STEP_POINT  = 5'h0b;
  localparam logic [4:0] STEP_TENTHS = 5'h0c;
  localparam logic [4:0] STEP_CR1    = 5'h0d;
  localparam logic [4:0] STEP_TYPE   = 5'h0e;
  localparam logic [4:0] STEP_CSUM   = 5'h0f;
  localparam logic [4:0] STEP_CR2    = 5'h10;
  localparam logic [4:0] STEP_LF     = 5'h11;
endpackage

// ==== rtl/power_up_report_link.sv ====
/*
  The single data line between the sensor end and the receiver end.
  Assumes the sensor end always drives the line; no bus sharing.
*/
`timescale 1ns/100ps
`default_nettype none
interface power_up_report_link;
  logic data_line;
  modport device (output data_line);
  modport host   (input  data_line);
endinterface
`default_nettype wire

// ==== rtl/report_fifo.sv ====
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; DEPTH must be a power of two.
*/
`timescale 1ns/100ps
`default_nettype none
module report_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("report_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_state_t;

  fifo_state_t state_r;
  fifo_state_t state_nxt;
  logic        full;
  logic        empty;

  // ------------------------------------------------------------------
  // Pointers with a wrap bit tell full from empty
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    full  = (state_r.wr[AW-1:0] == state_r.rd[AW-1:0]) &&
            (state_r.wr[AW] != state_r.rd[AW]);
    empty = (state_r.wr == state_r.rd);
    if (in_valid_in && !full) begin
      state_nxt.mem[state_r.wr[AW-1:0]] = in_data_in;
      state_nxt.wr = state_r.wr + 1'b1;
    end
    if (out_ready_in && !empty) begin
      state_nxt.rd = state_r.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = state_r.mem[state_r.rd[AW-1:0]];
endmodule // report_fifo
`default_nettype wire

// ==== rtl/power_up_serial_reporter.sv ====
/*
  Sensor end of the power-up report link: holds the line low while
  measuring, raises it, then, if the stored address is zero, sends one
  ASCII report at 1200 baud 8N1, and falls into command mode until the next power cycle.
  Assumes reset is the power cycle and the measurement values arrive
  as BCD with a one-cycle done strobe.
*/
// Overview of operation
// (RULE_01) Report only when stored address is zero
// (RULE_02) Characters sent at 1200 bits per second
// (RULE_03) Start bit, 8 data LSB first, stop
// (RULE_04) Line active high, never inverted
// (RULE_05) Line raised high within 100 ms
// (RULE_06) Line held low while measuring
// (RULE_07) Report starts unrequested once reading done
// (RULE_08) Receiver ignores edges before first start bit
// (RULE_09) After last character enter command mode
// (RULE_10) One report per power cycle only
// (RULE_11) Frame opens with a tab
// (RULE_12) Conductivity as decimal digits, uS/cm
// (RULE_13) Space, then temperature with one decimal
// (RULE_14) Carriage return after temperature
// (RULE_15) Sensor-type character follows
// (RULE_16) Checksum covers tab through type char
// (RULE_17) Checksum is sum mod 64 plus 32
// (RULE_18) Frame ends with CR then LF
// (RULE_19) Power alone starts measurement and report
// (RULE_20) Line idles high before and between characters
`timescale 1ns/100ps
`default_nettype none
module power_up_serial_reporter
  import power_up_report_pkg::*;
#(
  parameter int         BIT_CYCLES     = BIT_CYCLES_DEF,
  parameter int         POWERUP_CYCLES = POWERUP_CYCLES_DEF,
  // Arbitrary neutral sensor-type code
  parameter logic [7:0] SENSOR_TYPE    = 8'h61
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  address_in,
  input  wire logic        meas_done_in,
  input  wire logic [23:0] cond_bcd_in,
  input  wire logic        temp_neg_in,
  input  wire logic [11:0] temp_bcd_in,
  output logic             measuring_out,
  output logic             cmd_mode_out,
  power_up_report_link.device link
);
  if (BIT_CYCLES < 2 || BIT_CYCLES > 131071) begin : g_chk_bit
    $error("power_up_serial_reporter: BIT_CYCLES out of range");
  end
  if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 16777215) begin : g_chk_pu
    $error("power_up_serial_reporter: POWERUP_CYCLES out of range");
  end

  typedef enum logic [2:0] {
    PH_MEASURE, PH_ANNOUNCE, PH_SEND, PH_DRAIN, PH_CMD
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [23:0] timer;
    logic        meas_ok;
    logic [23:0] cond;
    logic        neg;
    logic [11:0] temp;
    logic [4:0]  step;
    logic [5:0]  sum;
    logic        tx_busy;
    logic [16:0] baud;
    logic [3:0]  bits;
    logic [9:0]  shift;
    logic        line;
    logic        measuring;
    logic        cmd;
  } dev_state_t;

  dev_state_t  state_r;
  dev_state_t  state_nxt;
  logic [7:0]  ch;
  logic        skip;
  logic        push_valid;
  logic        push_ready;
  logic        pop_valid;
  logic [7:0]  pop_data;
  logic        pop_ready;

  // ------------------------------------------------------------------
  // Character buffer between report builder and shifter
  // ------------------------------------------------------------------
  // Decouples building from the slow line; builder stalls when full
  report_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push_valid),
    .in_data_in    (ch),
    .in_ready_out  (push_ready),
    .out_valid_out (pop_valid),
    .out_data_out  (pop_data),
    .out_ready_in  (pop_ready)
  );

  // ------------------------------------------------------------------
  // Report character of the current step
  // ------------------------------------------------------------------
  function automatic logic [8:0] report_char(input dev_state_t s);
    logic [7:0] c;
    logic       sk;
    int         d;
    c  = CHAR_TAB;
    sk = 1'b0;
    d  = 0;
    if (s.step >= STEP_COND && s.step < STEP_SPACE) begin
      d  = int'(s.step - STEP_COND);
      c  = CHAR_ZERO + {4'h0, s.cond[(COND_DIGITS-1-d)*4 +: 4]}; // [RULE_12]
      // Leading zeros dropped, last digit always sent
      sk = (d < COND_DIGITS-1) &&
           ((s.cond >> ((COND_DIGITS-1-d)*4)) == 24'h000000);
    end else begin
      case (s.step)
        STEP_TAB:    c = CHAR_TAB; // [RULE_11]
        STEP_SPACE:  c = CHAR_SPACE; // [RULE_13]
        STEP_SIGN: begin
          c  = CHAR_MINUS;
          sk = !s.neg;
        end
        STEP_TENS: begin
          c  = CHAR_ZERO + {4'h0, s.temp[11:8]};
          sk = (s.temp[11:8] == 4'h0);
        end
        STEP_UNITS:  c = CHAR_ZERO + {4'h0, s.temp[7:4]}; // [RULE_13]
        STEP_POINT:  c = CHAR_POINT;
        STEP_TENTHS: c = CHAR_ZERO + {4'h0, s.temp[3:0]};
        STEP_CR1:    c = CHAR_CR; // [RULE_14]
        STEP_TYPE:   c = SENSOR_TYPE; // [RULE_15]
        STEP_CSUM:   c = CSUM_OFFSET + {2'b00, s.sum}; // [RULE_17]
        STEP_CR2:    c = CHAR_CR; // [RULE_18]
        STEP_LF:     c = CHAR_LF; // [RULE_18]
        default:     c = CHAR_TAB;
      endcase
    end
    return {sk, c};
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    {skip, ch} = report_char(state_r);
    push_valid = (state_r.phase == PH_SEND) && !skip;
    pop_ready  = !state_r.tx_busy;

    unique case (state_r.phase)
      PH_MEASURE: begin
        // Power alone starts the reading
        state_nxt.timer = state_r.timer + 24'h000001; // [RULE_19]
        if (meas_done_in) begin
          state_nxt.meas_ok = 1'b1;
          state_nxt.cond    = cond_bcd_in;
          state_nxt.neg     = temp_neg_in;
          state_nxt.temp    = temp_bcd_in;
        end
        // Raise at reading end, or at the deadline at the latest
        if (meas_done_in ||
            state_r.timer == 24'(POWERUP_CYCLES - 1)) begin // [RULE_05]
          state_nxt.phase = PH_ANNOUNCE;
        end
      end
      PH_ANNOUNCE: begin
        if (meas_done_in && !state_r.meas_ok) begin
          state_nxt.meas_ok = 1'b1;
          state_nxt.cond    = cond_bcd_in;
          state_nxt.neg     = temp_neg_in;
          state_nxt.temp    = temp_bcd_in;
        end
        if (state_r.meas_ok) begin
          state_nxt.step = STEP_TAB;
          state_nxt.sum  = 6'h00;
          if (address_in == ADDR_ZERO) begin // [RULE_01]
            state_nxt.phase = PH_SEND; // [RULE_07]
          end else begin
            state_nxt.phase = PH_CMD;
            state_nxt.cmd   = 1'b1;
          end
        end
      end
      PH_SEND: begin
        if (skip || push_ready) begin
          // Low six bits suffice for a modulo-64 sum
          if (!skip && state_r.step <= STEP_TYPE) begin
            state_nxt.sum = state_r.sum + ch[5:0]; // [RULE_16] [RULE_17]
          end
          if (state_r.step == STEP_LF) begin
            state_nxt.phase = PH_DRAIN;
          end else begin
            state_nxt.step = state_r.step + 5'h01;
          end
        end
      end
      PH_DRAIN: begin
        if (!pop_valid && !state_r.tx_busy) begin
          state_nxt.phase = PH_CMD; // [RULE_09]
          state_nxt.cmd   = 1'b1;
        end
      end
      PH_CMD: begin
        // Only a power cycle leaves this phase
        state_nxt.cmd = 1'b1; // [RULE_10]
      end
    endcase

    // Shifter: start, 8 data LSB first, stop
    if (!state_r.tx_busy) begin
      if (pop_valid) begin
        state_nxt.tx_busy = 1'b1;
        state_nxt.shift   = {1'b1, pop_data, 1'b0}; // [RULE_03]
        state_nxt.bits    = 4'h0;
        state_nxt.baud    = 17'h00000;
      end
    end else if (state_r.baud == 17'(BIT_CYCLES - 1)) begin // [RULE_02]
      state_nxt.baud  = 17'h00000;
      state_nxt.shift = {1'b1, state_r.shift[9:1]};
      if (state_r.bits == 4'(FRAME_BITS - 1)) begin
        state_nxt.tx_busy = 1'b0;
      end else begin
        state_nxt.bits = state_r.bits + 4'h1;
      end
    end else begin
      state_nxt.baud = state_r.baud + 17'h00001;
    end

    // Low while measuring, else idle high unless shifting
    if (state_nxt.phase == PH_MEASURE) begin
      state_nxt.line = 1'b0; // [RULE_06]
    end else if (state_nxt.tx_busy) begin
      state_nxt.line = state_nxt.shift[0]; // [RULE_04]
    end else begin
      state_nxt.line = 1'b1; // [RULE_20]
    end
    state_nxt.measuring = (state_nxt.phase == PH_MEASURE);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r           <= '0;
      state_r.phase     <= PH_MEASURE;
      state_r.measuring <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.data_line = state_r.line;
  assign measuring_out  = state_r.measuring;
  assign cmd_mode_out   = state_r.cmd;
endmodule // power_up_serial_reporter
`default_nettype wire

// ==== rtl/power_up_report_receiver.sv ====
/*
  Receiver end of the power-up report link: waits out the pre-report
  levels, decodes 1200 baud 8N1 characters and checks the checksum.
  Assumes the line is synchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module power_up_report_receiver
  import power_up_report_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  output logic [7:0]      byte_out,
  output logic            byte_valid_out,
  output logic            frame_err_out,
  output logic            csum_ok_out,
  output logic            csum_err_out,
  output logic            report_done_out,
  power_up_report_link.host link
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 131071) begin : g_chk
    $error("power_up_report_receiver: BIT_CYCLES out of range");
  end

  typedef enum logic [2:0] {
    RX_WAIT_HIGH, RX_HUNT, RX_START, RX_DATA, RX_STOP
  } rx_t;

  typedef struct packed {
    rx_t         rx;
    logic [16:0] baud;
    logic [2:0]  bits;
    logic [7:0]  shift;
    logic [1:0]  sec;
    logic [5:0]  sum;
    logic [7:0]  data;
    logic        valid;
    logic        ferr;
    logic        ok;
    logic        err;
    logic        done;
  } rx_state_t;

  rx_state_t state_r;
  rx_state_t state_nxt;
  logic      line;

  // ------------------------------------------------------------------
  // Character decoder and frame check
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt       = state_r;
    state_nxt.valid = 1'b0;
    state_nxt.ferr  = 1'b0;
    line            = link.data_line; // [RULE_04]
    unique case (state_r.rx)
      // Levels before the announce rise are not characters
      RX_WAIT_HIGH: if (line) state_nxt.rx = RX_HUNT; // [RULE_08]
      RX_HUNT: begin
        if (!line) begin
          state_nxt.rx   = RX_START;
          state_nxt.baud = 17'h00000;
        end
      end
      RX_START: begin
        if (state_r.baud == 17'(BIT_CYCLES / 2 - 1)) begin
          state_nxt.baud = 17'h00000;
          state_nxt.bits = 3'h0;
          // Glitch shorter than half a bit is rejected
          state_nxt.rx   = line ? RX_HUNT : RX_DATA;
        end else begin
          state_nxt.baud = state_r.baud + 17'h00001;
        end
      end
      RX_DATA: begin
        if (state_r.baud == 17'(BIT_CYCLES - 1)) begin // [RULE_02]
          state_nxt.baud  = 17'h00000;
          state_nxt.shift = {line, state_r.shift[7:1]}; // [RULE_03]
          state_nxt.bits  = state_r.bits + 3'h1;
          if (state_r.bits == 3'h7) state_nxt.rx = RX_STOP;
        end else begin
          state_nxt.baud = state_r.baud + 17'h00001;
        end
      end
      RX_STOP: begin
        if (state_r.baud == 17'(BIT_CYCLES - 1)) begin
          state_nxt.baud = 17'h00000;
          state_nxt.rx   = RX_HUNT;
          if (line) begin
            state_nxt.valid = 1'b1;
            state_nxt.data  = state_r.shift;
          end else begin
            state_nxt.ferr = 1'b1;
          end
        end else begin
          state_nxt.baud = state_r.baud + 17'h00001;
        end
      end
    endcase

    if (state_nxt.valid) begin
      if (state_nxt.data == CHAR_TAB) begin
        state_nxt.sec = 2'd0;
        state_nxt.sum = state_nxt.data[5:0];
        state_nxt.ok  = 1'b0;
        state_nxt.err = 1'b0;
      end else begin
        unique case (state_r.sec)
          2'd0: begin
            state_nxt.sum = state_r.sum + state_nxt.data[5:0];
            if (state_nxt.data == CHAR_CR) state_nxt.sec = 2'd1;
          end
          2'd1: begin
            state_nxt.sum = state_r.sum + state_nxt.data[5:0];
            state_nxt.sec = 2'd2;
          end
          2'd2: begin
            state_nxt.ok  = (state_nxt.data ==
                             CSUM_OFFSET + {2'b00, state_r.sum}); // [RULE_17]
            state_nxt.err = !state_nxt.ok;
            state_nxt.sec = 2'd3;
          end
          2'd3: begin
            if (state_nxt.data == CHAR_LF) state_nxt.done = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= '0;
      state_r.rx <= RX_WAIT_HIGH;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign byte_out        = state_r.data;
  assign byte_valid_out  = state_r.valid;
  assign frame_err_out   = state_r.ferr;
  assign csum_ok_out     = state_r.ok;
  assign csum_err_out    = state_r.err;
  assign report_done_out = state_r.done;
endmodule // power_up_report_receiver
`default_nettype wire

// ==== testbench/power_up_report_chk.sv ====
/*
  Checker for the power-up report link and both of its ends.
  Assumes BIT_CYCLES of 16 on both ends and placement beside the link.
*/
`timescale 1ns/100ps
`default_nettype none
module power_up_report_chk #(
  parameter int POWERUP_CYCLES = 200
) (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       data_line,
  input wire logic [7:0] address_in,
  input wire logic       meas_done_in,
  input wire logic       measuring_out,
  input wire logic       cmd_mode_out,
  input wire logic       byte_valid_out,
  input wire logic       report_done_out
);
  // ------------------------------------------------------------------
  // Cycles since power-up, saturating
  // ------------------------------------------------------------------
  int unsigned up_cnt_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up_cnt_r <= 0;
    end else if (up_cnt_r <= POWERUP_CYCLES) begin
      up_cnt_r <= up_cnt_r + 1;
    end
  end
  // ------------------------------------------------------------------
  // Cycles into the current character, zero between characters
  // ------------------------------------------------------------------
  // Data bits fall too; only a fall outside a frame is a start bit
  logic [7:0] frm_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frm_r <= 8'h00;
    end else if (frm_r == 8'h9f) begin
      frm_r <= 8'h00;
    end else if (frm_r != 8'h00 || $fell(data_line)) begin
      frm_r <= frm_r + 8'h01;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  AST_LOW_WHILE_MEASURING:
    assert property (measuring_out |-> !data_line)
    else $error("line high while measuring");
  AST_RAISE_DEADLINE:
    assert property (measuring_out |-> up_cnt_r < POWERUP_CYCLES)
    else $error("line not raised by deadline");
  AST_RISE_ON_DONE:
    assert property (meas_done_in && measuring_out |=>
                     data_line && !measuring_out)
    else $error("line not raised after reading done");
  AST_START_BIT:
    assert property ($fell(data_line) && frm_r == 8'h00 |->
                     !data_line[*8] ##8 !data_line)
    else $error("start bit too short");
  AST_STOP_AND_IDLE:
    assert property ($fell(data_line) && frm_r == 8'h00 |->
                     ##144 data_line ##15 data_line ##1 data_line)
    else $error("stop bit or idle gap low");
  AST_BYTE_TIMING:
    assert property ($fell(data_line) && frm_r == 8'h00 |->
                     ##[144:160] byte_valid_out)
    else $error("no character seen one frame after start");
  AST_REFUSE_ADDRESS:
    assert property (meas_done_in && measuring_out && address_in != 8'h30
                     |-> ##[1:3] cmd_mode_out)
    else $error("no command mode for non-zero address");
  AST_CMD_MODE_QUIET:
    assert property ($rose(cmd_mode_out) |-> data_line[*8])
    else $error("line active in command mode");
  AST_CMD_AFTER_LF:
    assert property ($rose(report_done_out) |-> ##[1:16] cmd_mode_out)
    else $error("no command mode after last character");
  // Main scenarios reached
  cover property (byte_valid_out);
  cover property ($rose(cmd_mode_out) && report_done_out);
  cover property (measuring_out && up_cnt_r == POWERUP_CYCLES - 1);
endmodule // power_up_report_chk
`default_nettype wire

// ==== testbench/power_up_serial_reporter_test.sv ====
/*
  Self-checking bench: reporter and receiver joined by the link.
  Assumes both ends run with BIT_CYCLES 16 and the reporter with POWERUP_CYCLES 200.
*/
`timescale 1ns/100ps
`default_nettype none
module power_up_serial_reporter_test;
  import power_up_report_pkg::*;
  localparam int PUC = 200;
  logic        clk_in, resetn_in, meas_done_in, temp_neg_in;
  logic [7:0]  address_in, byte_out;
  logic [23:0] cond_bcd_in;
  logic [11:0] temp_bcd_in;
  logic        measuring_out, cmd_mode_out, byte_valid_out, frame_err_out;
  logic        csum_ok_out, csum_err_out, report_done_out, data_line;
  int          mismatches, checks;
  power_up_report_link i_power_up_report_link();
  assign data_line = i_power_up_report_link.data_line;
  power_up_serial_reporter #(.BIT_CYCLES(16), .POWERUP_CYCLES(PUC))
    i_power_up_serial_reporter (.clk_in(clk_in), .resetn_in(resetn_in),
    .address_in(address_in), .meas_done_in(meas_done_in),
    .cond_bcd_in(cond_bcd_in), .temp_neg_in(temp_neg_in),
    .temp_bcd_in(temp_bcd_in), .measuring_out(measuring_out),
    .cmd_mode_out(cmd_mode_out), .link(i_power_up_report_link));
  power_up_report_receiver #(.BIT_CYCLES(16)) i_power_up_report_receiver (
    .clk_in(clk_in), .resetn_in(resetn_in), .byte_out(byte_out),
    .byte_valid_out(byte_valid_out), .frame_err_out(frame_err_out),
    .csum_ok_out(csum_ok_out), .csum_err_out(csum_err_out),
    .report_done_out(report_done_out), .link(i_power_up_report_link));
  // Checker's default deadline already matches PUC
  power_up_report_chk i_chk (.clk_in(clk_in), .resetn_in(resetn_in),
    .data_line(data_line), .address_in(address_in),
    .meas_done_in(meas_done_in), .measuring_out(measuring_out),
    .cmd_mode_out(cmd_mode_out), .byte_valid_out(byte_valid_out),
    .report_done_out(report_done_out));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Power cycle; reset also clears the one-report latch
  task automatic power_cycle(input logic [7:0] addr);
    @(negedge clk_in);
    resetn_in = 1'b0;
    address_in = addr;
    repeat (6) @(negedge clk_in);
    resetn_in = 1'b1;
  endtask
  task automatic pulse_done();
    meas_done_in = 1'b1;
    @(negedge clk_in);
    meas_done_in = 1'b0;
  endtask
  // Counts characters seen over a quiet span
  task automatic expect_silence(input int span);
    int n;
    n = 0;
    repeat (span) begin
      @(negedge clk_in);
      n += int'(byte_valid_out === 1'b1);
    end
    check("stray characters", 10'(n), 10'h000);
  endtask
  task automatic run_report(input string payload);
    logic [7:0] exp[$];
    logic [9:0] bits;
    int sum, idx, n, ferr;
    exp = {8'h09};
    foreach (payload[i]) exp.push_back(payload[i]);
    exp.push_back(8'h0d);
    exp.push_back(8'h61);
    sum = 0;
    foreach (exp[i]) sum += exp[i];
    exp.push_back(8'((sum % 64) + 32));
    exp.push_back(8'h0d);
    exp.push_back(8'h0a);
    ferr = 0;
    pulse_done();
    fork
      begin
        n = 0;
        while (data_line !== 1'b0 && n < 100) begin
          @(negedge clk_in);
          n++;
        end
        repeat (8) @(negedge clk_in);
        for (int j = 0; j < 10; j++) begin
          bits[j] = data_line;
          repeat (16) @(negedge clk_in);
        end
        check("first frame bits", bits, {1'b1, 8'h09, 1'b0});
      end
      begin
        idx = 0;
        for (int c = 0; c < 4000 && idx < exp.size(); c++) begin
          @(negedge clk_in);
          ferr += int'(frame_err_out === 1'b1);
          if (byte_valid_out === 1'b1) begin
            check("report char", {2'b00, byte_out}, {2'b00, exp[idx]});
            idx++;
          end
        end
      end
    join
    check("char count", 10'(idx), 10'(exp.size()));
    check("frame errors", 10'(ferr), 10'h000);
    check("csum ok", {9'h000, csum_ok_out}, 10'h001);
    check("csum err", {9'h000, csum_err_out}, 10'h000);
    repeat (20) @(negedge clk_in);
    check("cmd mode", {9'h000, cmd_mode_out}, 10'h001);
    check("idle line", {9'h000, data_line}, 10'h001);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_plain();
    power_cycle(8'h30);
    cond_bcd_in = 24'h005423;
    temp_neg_in = 1'b0;
    temp_bcd_in = 12'h223;
    repeat (3) @(negedge clk_in);
    check("low while measuring", {9'h000, data_line}, 10'h000);
    check("measuring", {9'h000, measuring_out}, 10'h001);
    run_report("5423 22.3");
  endtask
  // Boundary values: zero conductivity, negative one-digit temperature
  task automatic t_negative();
    power_cycle(8'h30);
    cond_bcd_in = 24'h000000;
    temp_neg_in = 1'b1;
    temp_bcd_in = 12'h051;
    run_report("0 -5.1");
  endtask
  task automatic t_deadline();
    power_cycle(8'h30);
    cond_bcd_in = 24'h120000;
    temp_neg_in = 1'b0;
    temp_bcd_in = 12'h500;
    repeat (PUC + 2) @(negedge clk_in);
    check("raised by deadline", {9'h000, data_line}, 10'h001);
    run_report("120000 50.0");
    pulse_done();
    expect_silence(400);
  endtask
  task automatic t_nonzero();
    power_cycle(8'h31);
    pulse_done();
    expect_silence(400);
    check("refused cmd mode", {9'h000, cmd_mode_out}, 10'h001);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Whole run is about 8000 cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end
  initial begin
    resetn_in = 1'b0;
    meas_done_in = 1'b0;
    address_in = 8'h30;
    cond_bcd_in = 24'h000000;
    temp_neg_in = 1'b0;
    temp_bcd_in = 12'h000;
    t_plain();
    t_negative();
    t_deadline();
    t_nonzero();
    stop_test();
  end
endmodule // power_up_serial_reporter_test
`default_nettype wire
